// >>> verilog/adc_seq_pkg.sv
// Shared constants and types for the internally clocked readout sequencer.
`default_nettype none
package adc_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int CLK_HZ         = 125_000_000;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int POR_TIME_NS    = 500_000;
  localparam int POR_CYCLES     = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_HZ      = 153_600;
  localparam int SAMPLE_CYCLES  = CLK_HZ / SAMPLE_HZ;
  localparam int POR_CNT_W      = 20;
  localparam int SAMPLE_CNT_W   = 10;
  localparam int FRAME_BITS     = 24;
  localparam int RESULT_W       = FRAME_BITS - 1;
  localparam int RISE_CNT_W     = 5;
  localparam int HALF_CNT_W     = 8;
  localparam int HALF_CYC_DEF   = 4;

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    S_POR   = 5'h01,
    S_CONV  = 5'h02,
    S_SLEEP = 5'h04,
    S_OUT   = 5'h08,
    S_EXT   = 5'h10
  } sys_state_t;

  typedef enum logic [3:0] {
    L_CONV  = 4'h1,
    L_SLEEP = 4'h2,
    L_HIGH  = 4'h4,
    L_LOW   = 4'h8
  } link_state_t;

  typedef struct packed {
    logic sck_pullup_en;
    logic cs_pullup_en;
    logic cs_discharge_en;
  } pin_ctl_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
  } ser_pins_t;

endpackage : adc_seq_pkg
`default_nettype wire

// >>> verilog/signal_sync.sv
// Two flip-flop synchroniser for a group of levels.
`timescale 1ns/1ps
`default_nettype none
module signal_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : signal_sync
`default_nettype wire

// >>> verilog/adc_readout_seq.sv
// Conversion cycle and internally clocked serial readout sequencer.
// Overview of operation
// - At power-on reset end, pick internal clock mode unless clock pin held low.
// - A clock pin too loaded for the pull-up selects external clock mode.
// - While converting, serial clock and data outputs both stay high.
// - At conversion end, clock and data go low and the device sleeps.
// - Continuous mode sleeps at least half a clock period, then starts output.
// - Output spans 24 rising edges; each new bit appears on a falling edge.
// - After the 24th rise, data goes high and clock stays high throughout conversion.
// - In autostart, chip select is pulled high while a conversion runs.
// - In autostart, sleep discharges chip select; output starts below threshold.
// - After the 24th rise in autostart, pull chip select high and reconvert.
// - In external mode, a chip select threshold crossing with clock high returns to internal mode; clock pull-up is off in external mode.
// - The input sampling network is clocked once every 813 cycles of the 125 MHz clock, near 153600 Hz.
`timescale 1ns/1ps
`default_nettype none
module adc_readout_seq
  import adc_seq_pkg::*;
#(
  parameter int POR_CYC  = adc_seq_pkg::POR_CYCLES,
  parameter int HALF_CYC = adc_seq_pkg::HALF_CYC_DEF
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic                          clk_osc,
  input  wire logic                          sck_i,
  input  wire logic                          cs_low_i,
  input  wire logic                          result_valid,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0] result,
  output var  adc_seq_pkg::ser_pins_t        ser,
  output var  adc_seq_pkg::pin_ctl_t         pin_ctl,
  output var  logic                          conv_start,
  output var  logic                          sample_tick,
  output var  logic                          ext_mode
);
  import adc_seq_pkg::*;

  if (POR_CYC < 1 || POR_CYC >= (1 << POR_CNT_W)) begin : g_bad_por
    $error("POR_CYC out of range");
  end
  if (HALF_CYC < 1 || HALF_CYC >= (1 << HALF_CNT_W)) begin : g_bad_half
    $error("HALF_CYC out of range");
  end

  localparam logic [POR_CNT_W-1:0]    POR_LAST  = POR_CNT_W'(POR_CYC - 1);
  localparam logic [SAMPLE_CNT_W-1:0] SAMP_LAST = SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [HALF_CNT_W-1:0]   HALF_LAST = HALF_CNT_W'(HALF_CYC - 1);
  localparam logic [RISE_CNT_W-1:0]   RISE_LAST = RISE_CNT_W'(FRAME_BITS);

  ////////////////////////////////////////////////////////////////////////////////
  // System clock domain: reset timing, mode choice, conversion and pin control.
  logic                    sck_hi;
  logic                    cs_low;
  logic                    fin_tog_s;
  logic                    fin_tog_d_ff;
  logic                    cs_low_d_ff;
  sys_state_t              state_ff;
  sys_state_t              nxt_state;
  logic [POR_CNT_W-1:0]    por_cnt_ff;
  logic [SAMPLE_CNT_W-1:0] samp_cnt_ff;
  logic [FRAME_BITS-1:0]   word_ff;
  logic                    done_tog_ff;
  logic                    start_tog_ff;
  logic                    fin_tog_ff;
  logic                    idle_ff;

  signal_sync #(.W(3), .RST_VAL(3'h6)) u_sync_sys (
    .clk (clk_sys),
    .rst (rst),
    .d   ({sck_i, cs_low_i, fin_tog_ff}),
    .q   ({sck_hi, cs_low, fin_tog_s})
  );

  wire fin_evt   = fin_tog_s ^ fin_tog_d_ff;
  wire cs_cross  = cs_low ^ cs_low_d_ff;
  wire por_done  = (state_ff == S_POR) && (por_cnt_ff == POR_LAST);
  wire conv_end  = (state_ff == S_CONV) && result_valid;
  wire sleep_go  = (state_ff == S_SLEEP) && cs_low;
  wire out_end   = (state_ff == S_OUT) && fin_evt;
  wire ext_back  = (state_ff == S_EXT) && cs_cross && sck_hi;
  wire samp_wrap = (samp_cnt_ff == SAMP_LAST);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_POR:   if (por_done) nxt_state = sck_hi ? S_CONV : S_EXT;
      S_CONV:  if (conv_end) nxt_state = S_SLEEP;
      S_SLEEP: if (sleep_go) nxt_state = S_OUT;
      S_OUT:   if (out_end) nxt_state = S_CONV;
      S_EXT:   if (ext_back) nxt_state = S_CONV;
      default: nxt_state = S_POR;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff     <= S_POR;
      por_cnt_ff   <= '0;
      fin_tog_d_ff <= 1'b0;
      cs_low_d_ff  <= 1'b1;
    end else if (ce) begin
      state_ff     <= nxt_state;
      por_cnt_ff   <= por_done ? por_cnt_ff : por_cnt_ff + 1'b1;
      fin_tog_d_ff <= fin_tog_s;
      cs_low_d_ff  <= cs_low;
    end
  end

  // Result is loaded on the end of conversion and held until the next one.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_ff      <= '0;
      done_tog_ff  <= 1'b0;
      start_tog_ff <= 1'b0;
    end else if (ce) begin
      if (conv_end) word_ff <= {1'b0, result};
      if (conv_end) done_tog_ff <= ~done_tog_ff;
      if (sleep_go) start_tog_ff <= ~start_tog_ff;
    end
  end

  // Pin controls and core strobes.
  wire nxt_conv  = (nxt_state == S_CONV);
  wire nxt_sleep = (nxt_state == S_SLEEP);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_ctl     <= '{sck_pullup_en: 1'b1, cs_pullup_en: 1'b0, cs_discharge_en: 1'b0};
      conv_start  <= 1'b0;
      ext_mode    <= 1'b0;
      idle_ff     <= 1'b1;
      samp_cnt_ff <= '0;
      sample_tick <= 1'b0;
    end else if (ce) begin
      pin_ctl.sck_pullup_en   <= (nxt_state != S_EXT);
      pin_ctl.cs_pullup_en    <= nxt_conv;
      pin_ctl.cs_discharge_en <= nxt_sleep;
      conv_start  <= nxt_conv && (state_ff != S_CONV);
      ext_mode    <= (nxt_state == S_EXT);
      idle_ff     <= (nxt_state == S_POR) || (nxt_state == S_EXT);
      samp_cnt_ff <= samp_wrap ? '0 : samp_cnt_ff + 1'b1;
      sample_tick <= samp_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator domain: serial clock generation and data shifting.
  logic                  done_s;
  logic                  start_s;
  logic                  ce_l;
  logic                  idle_l;
  logic                  done_d_ff;
  logic                  start_d_ff;
  link_state_t           lstate_ff;
  logic [HALF_CNT_W-1:0] half_cnt_ff;
  logic [RISE_CNT_W-1:0] rises_ff;
  logic [FRAME_BITS-1:0] shreg_ff;
  logic                  start_seen_ff;

  signal_sync #(.W(4), .RST_VAL(4'h3)) u_sync_link (
    .clk (clk_osc),
    .rst (rst),
    .d   ({done_tog_ff, start_tog_ff, ce, idle_ff}),
    .q   ({done_s, start_s, ce_l, idle_l})
  );

  wire done_evt  = done_s ^ done_d_ff;
  wire start_evt = start_s ^ start_d_ff;
  wire half_end  = (half_cnt_ff == HALF_LAST);
  wire go_first  = (lstate_ff == L_SLEEP) && half_end && (start_seen_ff || start_evt);
  wire last_rise = (lstate_ff == L_HIGH) && (rises_ff == RISE_LAST);

  always_ff @(posedge clk_osc or posedge rst) begin
    if (rst) begin
      lstate_ff     <= L_CONV;
      half_cnt_ff   <= '0;
      rises_ff      <= '0;
      shreg_ff      <= '0;
      start_seen_ff <= 1'b0;
      done_d_ff     <= 1'b0;
      start_d_ff    <= 1'b0;
      fin_tog_ff    <= 1'b0;
      ser           <= '{sck_o: 1'b1, sck_oe: 1'b0, sdo_o: 1'b1, sdo_oe: 1'b1};
    end else if (ce_l) begin
      done_d_ff  <= done_s;
      start_d_ff <= start_s;
      ser.sck_oe <= ~idle_l;
      half_cnt_ff <= half_end ? '0 : half_cnt_ff + 1'b1;
      unique case (lstate_ff)
        L_CONV: begin
          ser.sck_o <= 1'b1;
          ser.sdo_o <= 1'b1;
          if (done_evt) begin
            ser.sck_o     <= 1'b0;
            ser.sdo_o     <= 1'b0;
            shreg_ff      <= word_ff;
            half_cnt_ff   <= '0;
            start_seen_ff <= start_evt;
            lstate_ff     <= L_SLEEP;
          end
        end
        L_SLEEP: begin
          if (start_evt) start_seen_ff <= 1'b1;
          if (!half_end) half_cnt_ff <= half_cnt_ff + 1'b1;
          if (go_first) begin
            ser.sck_o   <= 1'b1;
            rises_ff    <= RISE_CNT_W'(1);
            half_cnt_ff <= '0;
            lstate_ff   <= L_HIGH;
          end
        end
        L_HIGH: begin
          if (last_rise) begin
            ser.sdo_o <= 1'b1;
            fin_tog_ff <= ~fin_tog_ff;
            lstate_ff <= L_CONV;
          end else if (half_end) begin
            ser.sck_o <= 1'b0;
            ser.sdo_o <= shreg_ff[FRAME_BITS-2];
            shreg_ff  <= {shreg_ff[FRAME_BITS-2:0], 1'b0};
            lstate_ff <= L_LOW;
          end
        end
        L_LOW: begin
          if (half_end) begin
            ser.sck_o <= 1'b1;
            rises_ff  <= rises_ff + 1'b1;
            lstate_ff <= L_HIGH;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the sequence.
  logic [HALF_CNT_W:0] sleep_age_ff;
  always_ff @(posedge clk_osc or posedge rst) begin
    if (rst) begin
      sleep_age_ff <= '0;
    end else if (ce_l) begin
      sleep_age_ff <= (lstate_ff == L_SLEEP) ? sleep_age_ff + 1'b1 : '0;
    end
  end

  a_conv_pins_high: assert property (@(posedge clk_osc) disable iff (rst)
    (lstate_ff == L_CONV) |-> (ser.sck_o && ser.sdo_o))
    else $error("Clock or data low during conversion.");

  a_done_pins_low: assert property (@(posedge clk_osc) disable iff (rst)
    (ce_l && lstate_ff == L_CONV && done_evt) |=> (!ser.sck_o && !ser.sdo_o))
    else $error("Pins not low after conversion end.");

  a_sleep_min_half: assert property (@(posedge clk_osc) disable iff (rst)
    (ce_l && go_first) |-> (sleep_age_ff >= (HALF_CNT_W + 1)'(HALF_CYC - 1)))
    else $error("Sleep shorter than half a clock period.");

  a_fall_shift_bit: assert property (@(posedge clk_osc) disable iff (rst)
    $fell(ser.sck_o) |-> (ser.sdo_o == $past(shreg_ff[FRAME_BITS-2])))
    else $error("Data bit not presented on falling edge.");

  a_rise_count_max: assert property (@(posedge clk_osc) disable iff (rst)
    (lstate_ff == L_HIGH || lstate_ff == L_LOW) |-> (rises_ff <= RISE_LAST))
    else $error("More than 24 rising edges in a frame.");

  a_frame_end_high: assert property (@(posedge clk_osc) disable iff (rst)
    (ce_l && last_rise) |=> (ser.sdo_o && ser.sck_o && lstate_ff == L_CONV))
    else $error("Frame end did not raise data and hold clock.");

  a_cs_pull_conv: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == S_CONV) |-> (pin_ctl.cs_pullup_en && !pin_ctl.cs_discharge_en))
    else $error("Chip select not pulled up while converting.");

  a_sleep_discharge: assert property (@(posedge clk_sys) disable iff (rst)
    (state_ff == S_SLEEP) |-> (pin_ctl.cs_discharge_en && pin_ctl.sck_pullup_en))
    else $error("Sleep without discharge or clock pull-up.");

  a_fin_restart: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && out_end) |=> (state_ff == S_CONV && pin_ctl.cs_pullup_en && conv_start))
    else $error("No new conversion after frame end.");

  a_por_mode_pick: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && por_done && sck_hi) |=> (state_ff == S_CONV && !ext_mode))
    else $error("Internal mode not chosen at reset end.");

  a_por_ext_pick: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && por_done && !sck_hi) |=> (state_ff == S_EXT && ext_mode))
    else $error("External mode not chosen with clock held low.");

  a_cs_low_start: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state_ff == S_SLEEP && cs_low) |=> (state_ff == S_OUT))
    else $error("Chip select low in sleep did not start output.");

  a_sample_rate: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && sample_tick) |-> (samp_cnt_ff == SAMPLE_CNT_W'(0)))
    else $error("Sampling tick out of step with its period.");

endmodule : adc_readout_seq
`default_nettype wire

// >>> verif/frame_rx.sv
// Far-side listener: resolves the clock wire and shifts in result frames.
`timescale 1ns/1ps
`default_nettype none
module frame_rx
  import adc_seq_pkg::*;
(
  input  wire logic                   rst,
  input  wire adc_seq_pkg::ser_pins_t ser,
  input  wire adc_seq_pkg::pin_ctl_t  pin_ctl,
  input  wire logic                   ext_en,
  input  wire logic                   ext_val,
  output var  logic                   sck_w,
  output var  logic [23:0]            bits,
  output var  logic [15:0]            n_rise
);
  // An undriven pin without its pull-up stays low under a heavy load.
  assign sck_w = ser.sck_oe ? ser.sck_o : (ext_en ? ext_val : pin_ctl.sck_pullup_en);

  // Every clock rise samples the data line, the ready flag first.
  always @(posedge sck_w or posedge rst) begin
    if (rst) begin
      n_rise <= 16'h0;
    end else begin
      bits   <= {bits[22:0], ser.sdo_o};
      n_rise <= n_rise + 16'h1;
    end
  end
endmodule : frame_rx
`default_nettype wire

// >>> verif/tb_adc_readout_seq.sv
// Self-checking bench for the readout sequencer with a listening far side.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_readout_seq;
  import adc_seq_pkg::*;
  localparam int POR  = 20;
  localparam int HALF = 4;
  logic                clk_sys, clk_osc, rst, cs_low_i, result_valid;
  logic                ext_en, ext_val, sck_w, conv_start, sample_tick, ext_mode;
  logic [RESULT_W-1:0] result;
  ser_pins_t           ser;
  pin_ctl_t            pin_ctl;
  logic [23:0]         bits;
  logic [15:0]         n_rise, n0, lf;
  logic                tick_seen;
  int                  mismatches, n_tests, k, gap, gap2;

  adc_readout_seq #(.POR_CYC(POR), .HALF_CYC(HALF)) u_adc_readout_seq (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .clk_osc(clk_osc), .sck_i(sck_w),
    .cs_low_i(cs_low_i), .result_valid(result_valid), .result(result), .ser(ser),
    .pin_ctl(pin_ctl), .conv_start(conv_start), .sample_tick(sample_tick),
    .ext_mode(ext_mode));
  frame_rx u_frame_rx (.rst(rst), .ser(ser), .pin_ctl(pin_ctl), .ext_en(ext_en),
    .ext_val(ext_val), .sck_w(sck_w), .bits(bits), .n_rise(n_rise));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    clk_osc = 1'b0;
    #3;
    forever #40 clk_osc = ~clk_osc;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  function automatic logic [23:0] frame_of(input logic [RESULT_W-1:0] r);
    return {1'b0, r};
  endfunction : frame_of
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic results();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic wait_start();
    k = 0;
    while (conv_start !== 1'b1 && k < 400) begin
      step();
      k++;
    end
    chk(k < 400, "no conversion start");
  endtask : wait_start

  // One conversion and its frame; the conversion has already been started.
  task automatic run_conv(input logic auto);
    logic [RESULT_W-1:0] r;
    chk(pin_ctl.cs_pullup_en === 1'b1, "cs pull-up off in conversion");
    lf = lfsr_next(lf);
    r = {lf[6:0], lf};
    repeat (4 + lf[4:0]) step();
    chk(sck_w === 1'b1 && ser.sdo_o === 1'b1, "lines low in conversion");
    @(posedge clk_sys);
    result_valid <= 1'b1;
    result <= r;
    @(posedge clk_sys);
    result_valid <= 1'b0;
    result <= ~r;
    n0 = n_rise;
    gap = 0;
    while (ser.sdo_o !== 1'b0 && gap < 200) begin
      step();
      gap++;
    end
    if (auto) begin
      repeat (300) step();
      chk(n_rise === n0 && ext_mode === 1'b0, "frame before threshold");
      chk(pin_ctl.cs_discharge_en === 1'b1, "no discharge in sleep");
      @(posedge clk_sys);
      cs_low_i <= 1'b1;
    end else begin
      chk(gap < 200 && sck_w === 1'b0, "no ready low");
    end
    gap = 0;
    while (n_rise === n0 && gap < 500) begin
      step();
      gap++;
    end
    if (!auto) begin
      chk(gap >= HALF * 10 - 1 && gap <= HALF * 10 + 11, "sleep length");
    end
    k = 0;
    while (n_rise !== n0 + 16'd24 && k < 4000) begin
      step();
      k++;
    end
    chk(bits === frame_of(r), "frame bits wrong");
    wait_start();
    chk(ser.sdo_o === 1'b1 && sck_w === 1'b1 && n_rise === n0 + 16'd24, "bad frame end");
    if (auto) begin
      @(posedge clk_sys);
      cs_low_i <= 1'b0;
    end
  endtask : run_conv

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (rst) begin
      tick_seen <= 1'b0;
      gap2 <= 0;
    end else if (sample_tick === 1'b1) begin
      if (tick_seen) begin
        chk(gap2 + 1 == SAMPLE_CYCLES, "sample tick period");
      end
      tick_seen <= 1'b1;
      gap2 <= 0;
    end else begin
      gap2 <= gap2 + 1;
    end
  end

  initial begin
    #400_000;
    mismatches++;
    results();
  end

  initial begin
    rst = 1'b1;
    cs_low_i = 1'b1;
    result_valid = 1'b0;
    result = '0;
    ext_en = 1'b0;
    ext_val = 1'b0;
    lf = 16'h004b;
    mismatches = 0;
    n_tests = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    wait_start();
    chk(ext_mode === 1'b0, "external mode with free pin");
    for (int i = 0; i < 3; i++) begin
      run_conv(1'b0);
    end
    @(posedge clk_sys);
    cs_low_i <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      run_conv(1'b1);
    end
    @(posedge clk_sys);
    rst <= 1'b1;
    cs_low_i <= 1'b1;
    ext_en <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (POR + 100) step();
    chk(ext_mode === 1'b1 && ser.sck_oe === 1'b0, "low pin kept internal");
    @(posedge clk_sys);
    ext_val <= 1'b1;
    repeat (5) step();
    @(posedge clk_sys);
    cs_low_i <= 1'b0;
    wait_start();
    chk(ext_mode === 1'b0, "crossing kept external mode");
    results();
  end
endmodule : tb_adc_readout_seq
`default_nettype wire
